// >>> pkg/cvtd_pkg.sv
`default_nettype none
package cvtd_pkg;
    // printed offsets are not multiples of four: kept as indices, byte address = 4 * index
    localparam logic [15:0] IDX_VCC_STABLE_TIMER    = 16'hfe04;
    localparam logic [15:0] IDX_CARD_DETECT_CONTROL = 16'hfe05;
    localparam logic [15:0] IDX_VCC_CONTROL         = 16'hfe03;
    localparam logic [15:0] IDX_IRQ_STATUS          = 16'hfe40;
    localparam logic [15:0] IDX_IRQ_MASK            = 16'hfe41;
    localparam logic [7:0]  RST_VCC_STABLE_TIMER    = 8'h0f;
    localparam logic [7:0]  RST_CARD_DETECT_CONTROL = 8'h00;
    localparam logic [7:0]  RST_VCC_CONTROL         = 8'h00;
    localparam logic [1:0]  RST_IRQ                 = 2'h0;
    // vcc_stable_timer fields
    localparam int OFF_DELAY_LSB = 4;
    localparam int ON_CHECK_LSB  = 0;
    // card_detect_control fields
    localparam int DEBOUNCE_BIT  = 7;
    localparam int DETECT_EN_BIT = 6;
    localparam int POLARITY_BIT  = 3;
    localparam int PULLUP_N_BIT  = 2;
    localparam int PULLDOWN_BIT  = 1;
    localparam int PRESENT_BIT   = 0;
    // vcc control fields
    localparam int VSEL_LSB      = 6;
    localparam int READY_ST_BIT  = 4;
    localparam int VOK_BIT       = 3;
    localparam int POWER_DOWN_BIT = 0;
    // irq bits
    localparam int IRQ_CARD_EVT  = 0;
    localparam int IRQ_VCC_FAIL  = 1;
    // debounce: 64 ms at 1 kHz tick
    localparam int DEBOUNCE_MS    = 64;
    localparam int TICK_HZ        = 1000;
    localparam logic [6:0] DEBOUNCE_TICKS = 7'(DEBOUNCE_MS * TICK_HZ / 1000);
    localparam logic [1:0] VSEL_OFF = 2'h0;
    localparam logic [1:0] BRESP_OKAY   = 2'h0;
    localparam logic [1:0] BRESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        ST_OFF      = 4'b0001,
        ST_ON_WAIT  = 4'b0010,
        ST_ACTIVE   = 4'b0100,
        ST_OFF_WAIT = 4'b1000
    } cvtd_state_t;
endpackage
`default_nettype wire

// >>> rtl/cvtd_top.sv
`timescale 1ns/10ps
`default_nettype none
module cvtd_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // axi4-lite write address / data / response
    input  wire logic [17:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [17:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // timing sources, synchronous single-cycle ticks
    input  wire logic        tick_32k,
    input  wire logic        tick_1k,
    // card supply side
    input  wire logic        supply_stable_status,
    input  wire logic        ready_in,
    input  wire logic        supply_fault,
    output logic             vcc_enable,
    output logic [1:0]       vcc_level,
    // card detect pin
    input  wire logic        card_detect_pin,
    output logic             pullup_on,
    output logic             pulldown_on,
    // interrupt
    output logic             irq
);
    cvtd_pkg::cvtd_state_t state_r;
    logic [7:0] tmr_r;
    logic [7:0] cdc_r;
    logic [1:0] vsel_r;
    logic       ready_start_r;
    logic       power_down_r;
    logic [1:0] ists_r;
    logic [1:0] imask_r;
    logic [3:0] cnt_r;
    logic [6:0] deb_r;
    logic       present_r;
    logic       vok_d_r;
    logic       aw_hold_r;
    logic       w_hold_r;
    logic [17:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;

    function automatic logic [15:0] reg_index(input logic [17:0] a);
        reg_index = a[17:2];
    endfunction

    // write path: address and data are accepted separately, in either order
    logic wr_go;
    logic [15:0] wr_idx;
    logic wr_hit;
    logic wr_en;
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign wr_go  = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign wr_idx = reg_index(awaddr_r);
    assign wr_en  = wr_go && wstrb_r[0];
    assign wr_hit = wr_idx == cvtd_pkg::IDX_VCC_STABLE_TIMER || wr_idx == cvtd_pkg::IDX_CARD_DETECT_CONTROL
                 || wr_idx == cvtd_pkg::IDX_VCC_CONTROL || wr_idx == cvtd_pkg::IDX_IRQ_STATUS
                 || wr_idx == cvtd_pkg::IDX_IRQ_MASK;

    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            awaddr_r     <= 18'h0;
            wdata_r      <= 32'h0;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cvtd_pkg::BRESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? cvtd_pkg::BRESP_OKAY : cvtd_pkg::BRESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read path
    logic [15:0] rd_idx;
    logic [7:0]  rd_byte;
    logic        rd_hit;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx = reg_index(s_axi_araddr);
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        if (rd_idx == cvtd_pkg::IDX_VCC_STABLE_TIMER) begin
            rd_byte = tmr_r;
        end else if (rd_idx == cvtd_pkg::IDX_CARD_DETECT_CONTROL) begin
            rd_byte = {cdc_r[7:1], present_r};
        end else if (rd_idx == cvtd_pkg::IDX_VCC_CONTROL) begin
            rd_byte = {vsel_r, 1'b0, ready_start_r, supply_stable_status, 2'b00, power_down_r};
        end else if (rd_idx == cvtd_pkg::IDX_IRQ_STATUS) begin
            rd_byte = {6'h0, ists_r};
        end else if (rd_idx == cvtd_pkg::IDX_IRQ_MASK) begin
            rd_byte = {6'h0, imask_r};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= cvtd_pkg::BRESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h0, rd_byte};
            s_axi_rresp  <= rd_hit ? cvtd_pkg::BRESP_OKAY : cvtd_pkg::BRESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // register writes
    logic wr_tmr;
    logic wr_cdc;
    logic wr_vcc;
    assign wr_tmr = wr_en && wr_idx == cvtd_pkg::IDX_VCC_STABLE_TIMER;
    assign wr_cdc = wr_en && wr_idx == cvtd_pkg::IDX_CARD_DETECT_CONTROL;
    assign wr_vcc = wr_en && wr_idx == cvtd_pkg::IDX_VCC_CONTROL;

    always_ff @(posedge mclk) begin
        if (reset) begin
            tmr_r   <= cvtd_pkg::RST_VCC_STABLE_TIMER;
            cdc_r   <= cvtd_pkg::RST_CARD_DETECT_CONTROL;
            imask_r <= cvtd_pkg::RST_IRQ;
            ready_start_r <= 1'b0;
            power_down_r  <= 1'b0;
        end else begin
            if (wr_tmr) begin
                tmr_r <= wdata_r[7:0];
            end
            if (wr_cdc) begin
                cdc_r <= {wdata_r[7:6], 2'b00, wdata_r[3:1], 1'b0};
            end
            if (wr_vcc) begin
                ready_start_r <= wdata_r[cvtd_pkg::READY_ST_BIT];
                power_down_r  <= wdata_r[cvtd_pkg::POWER_DOWN_BIT];
            end
            if (wr_en && wr_idx == cvtd_pkg::IDX_IRQ_MASK) begin
                imask_r <= wdata_r[1:0];
            end
        end
    end

    // card detect: no dependence on the card logic clock, runs on mclk and tick_1k
    logic pin_present;
    logic qualified;
    logic present_nxt;
    assign pin_present = cdc_r[cvtd_pkg::POLARITY_BIT] ? card_detect_pin : !card_detect_pin;
    assign qualified   = cdc_r[cvtd_pkg::DETECT_EN_BIT] && pin_present;
    always_comb begin
        if (!qualified) begin
            present_nxt = 1'b0;
        end else if (power_down_r || !cdc_r[cvtd_pkg::DEBOUNCE_BIT]) begin
            present_nxt = 1'b1;
        end else begin
            present_nxt = present_r || (tick_1k && deb_r == cvtd_pkg::DEBOUNCE_TICKS - 7'h1);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            deb_r     <= 7'h0;
            present_r <= 1'b0;
        end else begin
            present_r <= present_nxt;
            if (!qualified || present_r) begin
                deb_r <= 7'h0;
            end else if (tick_1k && deb_r != cvtd_pkg::DEBOUNCE_TICKS) begin
                deb_r <= deb_r + 7'h1;
            end
        end
    end

    assign pullup_on   = !cdc_r[cvtd_pkg::PULLUP_N_BIT];
    assign pulldown_on = cdc_r[cvtd_pkg::PULLDOWN_BIT];

    // card event on any change of presence
    logic card_evt;
    logic vok_fall;
    assign card_evt = present_nxt != present_r;
    assign vok_fall = vok_d_r && !supply_stable_status;

    // activation sequencer
    logic [3:0] on_cnt;
    logic [3:0] off_cnt;
    logic       on_end;
    logic       vcc_fail;
    logic       emergency;
    logic       vsel_zero_wr;
    logic       vsel_start_wr;
    assign on_cnt  = tmr_r[cvtd_pkg::ON_CHECK_LSB +: 4];
    assign off_cnt = tmr_r[cvtd_pkg::OFF_DELAY_LSB +: 4];
    assign vsel_start_wr = wr_vcc && wdata_r[cvtd_pkg::VSEL_LSB +: 2] != cvtd_pkg::VSEL_OFF;
    assign vsel_zero_wr  = wr_vcc && wdata_r[cvtd_pkg::VSEL_LSB +: 2] == cvtd_pkg::VSEL_OFF;
    // tick count reaches the field: interval = field * 30.5 us
    assign on_end   = state_r == cvtd_pkg::ST_ON_WAIT && on_cnt != 4'h0 && tick_32k && cnt_r == on_cnt - 4'h1;
    assign vcc_fail = on_end && !supply_stable_status;
    assign emergency = supply_fault || card_evt || (state_r == cvtd_pkg::ST_ACTIVE && vok_fall);

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= cvtd_pkg::ST_OFF;
            vsel_r  <= cvtd_pkg::RST_VCC_CONTROL[7:6];
            cnt_r   <= 4'h0;
            vok_d_r <= 1'b0;
        end else begin
            vok_d_r <= supply_stable_status;
            if (tick_32k) begin
                cnt_r <= cnt_r + 4'h1;
            end
            if (emergency && state_r != cvtd_pkg::ST_OFF) begin
                state_r <= cvtd_pkg::ST_OFF;
            end else begin
                unique case (state_r)
                    cvtd_pkg::ST_OFF: begin
                        if (vsel_start_wr && vsel_r == cvtd_pkg::VSEL_OFF) begin
                            vsel_r  <= wdata_r[cvtd_pkg::VSEL_LSB +: 2];
                            cnt_r   <= 4'h0;
                            state_r <= cvtd_pkg::ST_ON_WAIT;
                        end else if (vsel_zero_wr) begin
                            vsel_r <= cvtd_pkg::VSEL_OFF;
                        end
                    end
                    cvtd_pkg::ST_ON_WAIT: begin
                        if (vsel_zero_wr) begin
                            vsel_r  <= cvtd_pkg::VSEL_OFF;
                            state_r <= cvtd_pkg::ST_OFF;
                        end else if (vcc_fail) begin
                            vsel_r  <= cvtd_pkg::VSEL_OFF;
                            state_r <= cvtd_pkg::ST_OFF;
                        end else if (on_end) begin
                            state_r <= cvtd_pkg::ST_ACTIVE;
                        end else if (on_cnt == 4'h0 && ready_start_r && ready_in) begin
                            state_r <= cvtd_pkg::ST_ACTIVE;
                        end
                    end
                    cvtd_pkg::ST_ACTIVE: begin
                        if (vsel_zero_wr) begin
                            vsel_r <= cvtd_pkg::VSEL_OFF;
                            cnt_r  <= 4'h0;
                            state_r <= off_cnt == 4'h0 ? cvtd_pkg::ST_OFF : cvtd_pkg::ST_OFF_WAIT;
                        end
                    end
                    cvtd_pkg::ST_OFF_WAIT: begin
                        if (tick_32k && cnt_r == off_cnt - 4'h1) begin
                            state_r <= cvtd_pkg::ST_OFF;
                        end
                    end
                    default: begin
                        state_r <= cvtd_pkg::ST_OFF;
                    end
                endcase
            end
            // an emergency keeps the selection, but a failed check clears it even then
            if (vcc_fail) begin
                vsel_r <= cvtd_pkg::VSEL_OFF;
            end
        end
    end

    assign vcc_enable = state_r != cvtd_pkg::ST_OFF;
    assign vcc_level  = vsel_r;

    // sticky status, write one to clear; set wins over clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            ists_r <= cvtd_pkg::RST_IRQ;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == cvtd_pkg::IRQ_CARD_EVT && (card_evt || vcc_fail)) || (i == cvtd_pkg::IRQ_VCC_FAIL && vcc_fail)) begin
                    ists_r[i] <= 1'b1;
                end else if (wr_en && wr_idx == cvtd_pkg::IDX_IRQ_STATUS && wdata_r[i]) begin
                    ists_r[i] <= 1'b0;
                end
            end
        end
    end
    assign irq = |(ists_r & imask_r);

    a_fail_clears_sel: assert property (@(posedge mclk) disable iff (reset)
        vcc_fail |=> vsel_r == cvtd_pkg::VSEL_OFF && !vcc_enable && ists_r[cvtd_pkg::IRQ_CARD_EVT])
        else $error("vcc fail not handled");
    a_removal_fast: assert property (@(posedge mclk) disable iff (reset)
        !qualified |=> !present_r) else $error("presence not cleared");
    a_detect_off: assert property (@(posedge mclk) disable iff (reset)
        !cdc_r[cvtd_pkg::DETECT_EN_BIT] |=> !present_r) else $error("presence while disabled");
    a_pull_ctrl: assert property (@(posedge mclk) disable iff (reset)
        pullup_on == !cdc_r[cvtd_pkg::PULLUP_N_BIT] && pulldown_on == cdc_r[cvtd_pkg::PULLDOWN_BIT])
        else $error("pull control wrong");
    a_event_sets: assert property (@(posedge mclk) disable iff (reset)
        $changed(present_r) |-> ists_r[cvtd_pkg::IRQ_CARD_EVT]) else $error("card event lost");
    a_bypass_debounce: assert property (@(posedge mclk) disable iff (reset)
        power_down_r && qualified |=> present_r) else $error("power-down debounce");
    a_no_early_present: assert property (@(posedge mclk) disable iff (reset)
        cdc_r[cvtd_pkg::DEBOUNCE_BIT] && !power_down_r && !present_r
        && deb_r < cvtd_pkg::DEBOUNCE_TICKS - 7'h1 |=> !present_r) else $error("early presence");
    a_zero_off_delay: assert property (@(posedge mclk) disable iff (reset)
        state_r == cvtd_pkg::ST_ACTIVE && vsel_zero_wr && off_cnt == 4'h0 && !emergency |=> state_r == cvtd_pkg::ST_OFF)
        else $error("off delay not zero");
    a_emergency_now: assert property (@(posedge mclk) disable iff (reset)
        supply_fault && vcc_enable |=> !vcc_enable) else $error("emergency delayed");
    a_no_timeout_zero: assert property (@(posedge mclk) disable iff (reset)
        state_r == cvtd_pkg::ST_ON_WAIT && on_cnt == 4'h0 && !(ready_start_r && ready_in)
        && !emergency && !vsel_zero_wr |=> state_r == cvtd_pkg::ST_ON_WAIT) else $error("timeout with zero");
    c_activate: cover property (@(posedge mclk) state_r == cvtd_pkg::ST_ON_WAIT ##[1:600] state_r == cvtd_pkg::ST_ACTIVE);
    c_off_delay: cover property (@(posedge mclk) state_r == cvtd_pkg::ST_OFF_WAIT ##1 state_r == cvtd_pkg::ST_OFF);
    c_vcc_fail: cover property (@(posedge mclk) vcc_fail);
    c_present: cover property (@(posedge mclk) $rose(present_r) && cdc_r[7]);
endmodule
`default_nettype wire

// >>> test/cvtd_slot_model.sv
`timescale 1ns/10ps
`default_nettype none
module cvtd_slot_model #(
    parameter int P32 = 16,
    parameter int P1K = 10
) (
    // clock
    input  wire logic mclk,
    // bench controls
    input  wire logic t32_run,
    input  wire logic card_in,
    input  wire logic closed_level,
    input  wire logic supply_good,
    // device side
    input  wire logic vcc_enable,
    input  wire logic pullup_on,
    input  wire logic pulldown_on,
    output logic      tick_32k,
    output logic      tick_1k,
    output logic      card_detect_pin,
    output logic      supply_stable_status,
    output logic      ready_in
);
    int         c32    = 0;
    int         c1k    = 0;
    logic [3:0] ramp_r = 4'h0;
    initial begin
        tick_32k        = 1'b0;
        tick_1k         = 1'b0;
        card_detect_pin = 1'b1;
    end
    // time bases shortened so a 64-tick debounce fits the run
    always @(posedge mclk) begin
        c32      <= (c32 == P32 - 1) ? 0 : c32 + 1;
        c1k      <= (c1k == P1K - 1) ? 0 : c1k + 1;
        tick_32k <= t32_run && (c32 == P32 - 1);
        tick_1k  <= (c1k == P1K - 1);
    end
    // supply settles a few cycles after enable and collapses at once when cut
    always @(posedge mclk) begin
        ramp_r <= vcc_enable ? {ramp_r[2:0], supply_good} : 4'h0;
    end
    assign supply_stable_status = ramp_r[3];
    assign ready_in             = ramp_r[3];
    // open contact follows the pull; unpulled it is not trusted, so it toggles
    always @(posedge mclk) begin
        if (card_in) begin
            card_detect_pin <= closed_level;
        end else if (pullup_on && !pulldown_on) begin
            card_detect_pin <= 1'b1;
        end else if (pulldown_on && !pullup_on) begin
            card_detect_pin <= 1'b0;
        end else begin
            card_detect_pin <= ~card_detect_pin;
        end
    end
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [17:0] A_TMR = 18'(4 * cvtd_pkg::IDX_VCC_STABLE_TIMER);
    localparam logic [17:0] A_CDC = 18'(4 * cvtd_pkg::IDX_CARD_DETECT_CONTROL);
    localparam logic [17:0] A_VCC = 18'(4 * cvtd_pkg::IDX_VCC_CONTROL);
    localparam logic [17:0] A_IST = 18'(4 * cvtd_pkg::IDX_IRQ_STATUS);
    localparam logic [17:0] A_IMK = 18'(4 * cvtd_pkg::IDX_IRQ_MASK);
    logic mclk = 1'b0, reset = 1'b1;
    logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic tick_32k, tick_1k, supply_stable_status, ready_in, vcc_enable, pin, pullup_on, pulldown_on, irq;
    logic [1:0] vcc_level;
    logic supply_fault = 0, t32_run = 1, card_in = 0, closed_level = 1, supply_good = 1;
    int miscompares = 0, n_checks = 0, cycles = 0;
    always #20 mclk = ~mclk;
    cvtd_top dut_u (.mclk(mclk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .tick_32k(tick_32k), .tick_1k(tick_1k), .supply_stable_status(supply_stable_status),
        .ready_in(ready_in), .supply_fault(supply_fault), .vcc_enable(vcc_enable), .vcc_level(vcc_level),
        .card_detect_pin(pin), .pullup_on(pullup_on), .pulldown_on(pulldown_on), .irq(irq));
    cvtd_slot_model #(.P32(16), .P1K(10)) slot_u (.mclk(mclk), .t32_run(t32_run), .card_in(card_in),
        .closed_level(closed_level), .supply_good(supply_good), .vcc_enable(vcc_enable),
        .pullup_on(pullup_on), .pulldown_on(pulldown_on), .tick_32k(tick_32k), .tick_1k(tick_1k),
        .card_detect_pin(pin), .supply_stable_status(supply_stable_status), .ready_in(ready_in));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // entered just after a clock edge; address and data offered together
    task automatic wr(input logic [17:0] a, input logic [31:0] v);
        bit aw_t, w_t;
        aw_t = 0;
        w_t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(aw_t && w_t)) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_t = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_t = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [17:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic t_reset();
        rd(A_TMR); chk(d, 32'h0000000f);
        rd(A_CDC); chk(d, 32'h00000000);
        chk(32'(pullup_on), 32'h1); chk(32'(pulldown_on), 32'h0);
        chk(32'(irq), 32'h0);
        rd(18'h00100); chk(32'(r), 32'(cvtd_pkg::BRESP_SLVERR));
        wr(18'h00100, 32'hff); chk(32'(r), 32'(cvtd_pkg::BRESP_SLVERR));
        s_axi_wstrb <= 4'h0; wr(A_TMR, 32'h55); s_axi_wstrb <= 4'hf;
        rd(A_TMR); chk(d, 32'h0000000f); chk(32'(r), 32'(cvtd_pkg::BRESP_OKAY));
        wr(A_CDC, 32'h07); chk(32'(r), 32'(cvtd_pkg::BRESP_OKAY)); cyc(2);
        chk(32'(pullup_on), 32'h0); chk(32'(pulldown_on), 32'h1);
        rd(A_CDC); chk(d, 32'h00000006);
        wr(A_CDC, 32'h00);
        $display("reset and pulls done");
    endtask
    task automatic t_on_fail();
        wr(A_TMR, 32'h03); supply_good <= 0; wr(A_VCC, 32'h40);
        chk(32'(vcc_level), 32'h1); cyc(26); chk(32'(vcc_level), 32'h1);
        cyc(26); chk(32'(vcc_level), 32'h0); chk(32'(vcc_enable), 32'h0);
        rd(A_VCC); chk(d & 32'hc0, 32'h0);
        rd(A_IST); chk(d, 32'h3); chk(32'(irq), 32'h0);
        wr(A_IMK, 32'h2); cyc(2); chk(32'(irq), 32'h1);
        wr(A_IST, 32'h2); cyc(2); chk(32'(irq), 32'h0);
        rd(A_IST); chk(d, 32'h1);
        wr(A_IST, 32'h1); wr(A_IMK, 32'h0); supply_good <= 1;
        $display("on-check failure done");
    endtask
    task automatic t_on_off();
        wr(A_TMR, 32'h43); wr(A_VCC, 32'h80); cyc(60);
        chk(32'(vcc_enable), 32'h1);
        rd(A_VCC); chk(d, 32'h88);
        wr(A_VCC, 32'h00); cyc(40); chk(32'(vcc_enable), 32'h1);
        cyc(32); chk(32'(vcc_enable), 32'h0);
        wr(A_VCC, 32'hc0); cyc(60); chk(32'(vcc_enable), 32'h1);
        supply_fault <= 1; cyc(3); chk(32'(vcc_enable), 32'h0);
        supply_fault <= 0; rd(A_VCC); chk(d & 32'hc0, 32'hc0);
        wr(A_VCC, 32'h00); wr(A_VCC, 32'h40); cyc(60);
        supply_good <= 0; cyc(8); chk(32'(vcc_enable), 32'h0);
        wr(A_VCC, 32'h00); supply_good <= 1; wr(A_IST, 32'h3);
        $display("off delay and emergency done");
    endtask
    task automatic t_field0();
        // supply never settles: a zero field must not time out, and the wait is left at once
        wr(A_TMR, 32'h40); supply_good <= 0; wr(A_VCC, 32'h40); cyc(100);
        chk(32'(vcc_enable), 32'h1); rd(A_IST); chk(d, 32'h0);
        wr(A_VCC, 32'h00); cyc(3); chk(32'(vcc_enable), 32'h0);
        // ready-start with ready high reaches the active state, so the off delay applies
        supply_good <= 1; wr(A_VCC, 32'h50); cyc(100);
        wr(A_VCC, 32'h00); cyc(3); chk(32'(vcc_enable), 32'h1);
        cyc(80); chk(32'(vcc_enable), 32'h0);
        wr(A_TMR, 32'h00);
        for (int s = 1; s < 4; s++) begin
            wr(A_VCC, 32'((s << 6) | 8'h10)); cyc(100);
            chk(32'(vcc_level), 32'(s));
            chk(32'(vcc_enable), 32'h1);
            wr(A_VCC, 32'h00); cyc(3); chk(32'(vcc_enable), 32'h0);
        end
        $display("untimed activation done");
    endtask
    task automatic t_detect();
        t32_run <= 0;
        wr(A_CDC, 32'h0e); wr(A_CDC, 32'h4e);
        card_in <= 1; cyc(4); rd(A_CDC); chk(d, 32'h4f);
        rd(A_IST); chk(d, 32'h1);
        wr(A_IMK, 32'h1); cyc(2); chk(32'(irq), 32'h1);
        wr(A_IST, 32'h1); cyc(2); chk(32'(irq), 32'h0);
        card_in <= 0; cyc(4); rd(A_CDC); chk(d, 32'h4e);
        rd(A_IST); chk(d, 32'h1); wr(A_IST, 32'h1);
        closed_level <= 0; wr(A_CDC, 32'h00); wr(A_CDC, 32'h40);
        card_in <= 1; cyc(4); rd(A_CDC); chk(d, 32'h41);
        wr(A_CDC, 32'h00); cyc(4); rd(A_CDC); chk(d, 32'h00);
        card_in <= 0; wr(A_IST, 32'h3); wr(A_IMK, 32'h0); t32_run <= 1;
        $display("detect done");
    endtask
    task automatic t_debounce();
        closed_level <= 1; wr(A_CDC, 32'h8e); wr(A_CDC, 32'hce);
        card_in <= 1; cyc(400); card_in <= 0; cyc(3); card_in <= 1;
        cyc(600); rd(A_CDC); chk(d, 32'hce);
        cyc(60); rd(A_CDC); chk(d, 32'hcf);
        card_in <= 0; cyc(3); rd(A_CDC); chk(d, 32'hce);
        wr(A_VCC, 32'h01); card_in <= 1; cyc(4);
        rd(A_CDC); chk(d, 32'hcf);
        card_in <= 0; wr(A_VCC, 32'h00); wr(A_CDC, 32'h00); wr(A_IST, 32'h3);
        $display("debounce done");
    endtask
    initial begin
        cyc(4);
        reset <= 0;
        @(posedge mclk);
        t_reset();
        t_on_fail();
        t_on_off();
        t_field0();
        t_detect();
        t_debounce();
        complete_run();
    end
endmodule
`default_nettype wire
